// ==== core/ufc_pkg.sv ====
package ufc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map (byte addresses, one word each)
  localparam logic [7:0] ADDR_DATA = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CTRL1 = 8'h08;
  localparam logic [7:0] ADDR_CTRL2 = 8'h0c;
  localparam logic [7:0] ADDR_BAUD = 8'h10;

  // Status bit positions
  localparam int ST_TDE = 0;
  localparam int ST_TXC = 1;
  localparam int ST_RXD = 2;
  localparam int ST_NEF = 3;
  localparam int ST_FEF = 4;

  // Control one bit positions
  localparam int C1_WL = 0;
  localparam int C1_TRANSMIT_ENABLE_CTL = 1;
  localparam int C1_RECEIVE_ENABLE_CTL = 2;
  localparam int C1_SEND_BREAK_CTL = 3;
  localparam int C1_TDEIE = 4;
  localparam int C1_TXCIE = 5;
  localparam int C1_RXDIE = 6;

  // Control two field position
  localparam int C2_STOP_LSB = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [15:0] BAUD_RST = 16'h001b;
  localparam logic [1:0] STOP_RST = 2'h0;

  // Stop length codes
  localparam logic [1:0] STOP_ONE = 2'h0;
  localparam logic [1:0] STOP_HALF = 2'h1;
  localparam logic [1:0] STOP_TWO = 2'h2;
  localparam logic [1:0] STOP_ONE_HALF = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Sample counts in 1/16 bit ticks, then data and frame bit counts
  localparam logic [5:0] TICKS_BIT = 6'h10;
  localparam logic [5:0] TICKS_HALF = 6'h08;
  localparam logic [5:0] TICKS_ONE_HALF = 6'h18;
  localparam logic [5:0] TICKS_TWO = 6'h20;
  localparam logic [5:0] PT_A0 = 6'h03;
  localparam logic [5:0] PT_A1 = 6'h05;
  localparam logic [5:0] PT_A2 = 6'h07;
  localparam logic [5:0] PT_MID = 6'h08;
  localparam logic [5:0] PT_DECIDE = 6'h0a;
  localparam logic [3:0] BITS_8 = 4'h8;
  localparam logic [3:0] BITS_9 = 4'h9;
  localparam logic [3:0] FRAME_8 = 4'ha;
  localparam logic [3:0] FRAME_9 = 4'hb;

  ////////////////////////////////////////////////////////////////////////////
  // State machines
  typedef enum logic [2:0] {
    TXS_OFF, TXS_PREAMBLE, TXS_READY, TXS_START, TXS_DATA, TXS_STOP,
    TXS_BRK_LOW, TXS_BRK_STOP
  } ufc_tx_state_t;

  typedef enum logic [1:0] {RXS_IDLE, RXS_START, RXS_DATA, RXS_STOP} ufc_rx_state_t;

endpackage : ufc_pkg

// ==== core/ufc_baud_gen.sv ====
`timescale 1ns/1ps
`default_nettype none

module ufc_baud_gen #(
  parameter int DIV_W = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Control
  input wire logic run_i,
  input wire logic [DIV_W-1:0] div_i,
  // Sixteen-per-bit sample enable
  output logic tick_o
);

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic tick;
  } ufc_baud_st_t;

  ufc_baud_st_t s;
  ufc_baud_st_t next_s;

  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (!run_i) begin
      next_s.cnt = '0;
    end else if ((s.cnt + {{(DIV_W-1){1'b0}}, 1'b1}) >= div_i) begin
      next_s.cnt = '0;
      next_s.tick = 1'b1;
    end else begin
      next_s.cnt = s.cnt + {{(DIV_W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick_o = s.tick;

endmodule : ufc_baud_gen

`default_nettype wire

// ==== core/ufc_core.sv ====
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Words are 8 bits when word length select is 0, 9 when 1.
// - Transmit line is low for every start bit and high for every stop bit.
// - Idle frame is all ones: 10 bit periods for 8-bit, 11 for 9-bit.
// - Send break gives 10 or 11 low bit periods then one high stop bit.
// - Hardware clears send break as the break stop bit starts; software waits.
// - Send break cleared before the break begins sends no break.
// - Data goes out LSB first, after one start bit, before configured stop bits.
// - Stop field: 00 one, 01 half, 10 two, 11 one and a half.
// - Enabling the transmitter sends one idle frame before the first data frame.
// - A data register write into holding clears the transmit buffer empty flag; a direct load sets it.
// - Buffer empty sets when holding data moves to the shifter; may interrupt.
// - Write to idle shifter loads directly; write while busy waits in holding.
// - Complete sets at frame end with buffer empty; cleared by sequence or zero write.
// - Start candidate begins at a falling edge after three high samples.
// - Points 3,5,7,8,9,10 all zero accept start with no noise flag.
// - Two of three zeros in each group accept start and set noise flag.
// - Otherwise start detection ends silently and waits for the next falling edge.
// - Half stop bit is not sampled: no framing error, no break detection.
// - One stop bit is judged from points 8, 9 and 10.
// - One and a half stop: sample points 16-18; low means framing error.
// - Two stop bits: judge first only at 8-10, done at its end.
// - Frame end moves shifter to receive data, sets done, may interrupt.
module ufc_core #(
  parameter int DIV_W = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // Serial pins
  input wire logic rx_i,
  output logic tx_o,
  // Interrupt request
  output logic irq_o
);

  typedef struct packed {
    // Control
    logic wl;
    logic transmit_enable_ctl;
    logic receive_enable_ctl;
    logic send_break_ctl;
    logic tdeie;
    logic txcie;
    logic rxdie;
    logic [1:0] stop;
    logic [DIV_W-1:0] baud;
    // Transmitter
    ufc_pkg::ufc_tx_state_t tx_st;
    logic [5:0] tx_tick;
    logic [3:0] tx_bits;
    logic [8:0] tx_shift;
    logic [8:0] hold;
    logic hold_full;
    logic tde;
    logic tx_complete_flag;
    logic txd;
    // Receiver
    logic rx_s1;
    logic rx_s2;
    ufc_pkg::ufc_rx_state_t rx_st;
    logic [5:0] rx_tick;
    logic [3:0] rx_bits;
    logic [2:0] rx_hist;
    logic [1:0] za;
    logic [1:0] zb;
    logic rx_noise;
    logic [8:0] rx_shift;
    logic [8:0] rx_data;
    logic rx_done;
    logic noise_error_flag;
    logic fef;
    // Bus
    logic sts_seen;
    logic [31:0] rdata;
  } ufc_state_t;

  ufc_state_t s;
  ufc_state_t next_s;
  logic tick;
  logic [5:0] tx_lim;
  logic [5:0] p;
  logic [5:0] sp;
  logic zero_now;
  logic wr_data;
  logic rd_data;
  logic wr_sts;
  logic rd_sts;
  logic wr_ctl1;
  logic direct_ok;
  logic rx_end;
  logic tx_end;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [3:0] data_bits(input logic wl);
    data_bits = wl ? ufc_pkg::BITS_9 : ufc_pkg::BITS_8;
  endfunction : data_bits

  function automatic logic [3:0] frame_bits(input logic wl);
    frame_bits = wl ? ufc_pkg::FRAME_9 : ufc_pkg::FRAME_8;
  endfunction : frame_bits

  function automatic logic [5:0] stop_ticks(input logic [1:0] code);
    unique case (code)
      ufc_pkg::STOP_HALF: stop_ticks = ufc_pkg::TICKS_HALF;
      ufc_pkg::STOP_TWO: stop_ticks = ufc_pkg::TICKS_TWO;
      ufc_pkg::STOP_ONE_HALF: stop_ticks = ufc_pkg::TICKS_ONE_HALF;
      default: stop_ticks = ufc_pkg::TICKS_BIT;
    endcase
  endfunction : stop_ticks

  ////////////////////////////////////////////////////////////////////////////
  // Shared baud generator
  ufc_baud_gen #(
    .DIV_W(DIV_W)
  ) u_baud (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .run_i(s.transmit_enable_ctl | s.receive_enable_ctl),
    .div_i(s.baud),
    .tick_o(tick)
  );

  assign wr_data = wr_i && (addr_i == ufc_pkg::ADDR_DATA);
  assign rd_data = rd_i && (addr_i == ufc_pkg::ADDR_DATA);
  assign wr_sts = wr_i && (addr_i == ufc_pkg::ADDR_STATUS);
  assign rd_sts = rd_i && (addr_i == ufc_pkg::ADDR_STATUS);
  assign wr_ctl1 = wr_i && (addr_i == ufc_pkg::ADDR_CTRL1);
  assign direct_ok = (s.tx_st == ufc_pkg::TXS_READY) && !s.hold_full && !s.send_break_ctl;
  assign tx_lim = (s.tx_st == ufc_pkg::TXS_STOP) ? stop_ticks(s.stop) : ufc_pkg::TICKS_BIT;
  assign p = s.rx_tick + 6'h01;
  assign sp = (s.stop == ufc_pkg::STOP_ONE_HALF) ? ufc_pkg::TICKS_BIT : ufc_pkg::PT_MID;
  assign zero_now = !s.rx_s2;
  // Frame end events; a flag set here wins over a software clear in the same cycle
  assign rx_end = s.receive_enable_ctl && tick && (s.rx_st == ufc_pkg::RXS_STOP) &&
    (p == ((s.stop == ufc_pkg::STOP_TWO) ? ufc_pkg::TICKS_BIT : stop_ticks(s.stop)));
  assign tx_end = s.transmit_enable_ctl && tick && (s.tx_st == ufc_pkg::TXS_STOP) && !(s.tx_tick + 6'h01 < tx_lim) && s.tde;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_s = s;
    next_s.rdata = 32'h0000_0000;
    next_s.rx_s1 = rx_i;
    next_s.rx_s2 = s.rx_s1;

    // Transmitter
    if (!s.transmit_enable_ctl) begin
      next_s.tx_st = ufc_pkg::TXS_OFF;
      next_s.txd = 1'b1;
    end else if (s.tx_st == ufc_pkg::TXS_OFF) begin
      next_s.tx_st = ufc_pkg::TXS_PREAMBLE;
      next_s.tx_tick = 6'h00;
      next_s.tx_bits = 4'h0;
      next_s.txd = 1'b1;
    end else if (s.tx_st == ufc_pkg::TXS_READY) begin
      next_s.tx_tick = 6'h00;
      next_s.tx_bits = 4'h0;
      if (s.send_break_ctl) begin
        next_s.tx_st = ufc_pkg::TXS_BRK_LOW;
        next_s.txd = 1'b0;
      end else if (s.hold_full) begin
        next_s.tx_st = ufc_pkg::TXS_START;
        next_s.tx_shift = s.hold;
        next_s.hold_full = 1'b0;
        next_s.tde = 1'b1;
        next_s.txd = 1'b0;
      end
    end else if (tick) begin
      if (s.tx_tick + 6'h01 < tx_lim) begin
        next_s.tx_tick = s.tx_tick + 6'h01;
      end else begin
        next_s.tx_tick = 6'h00;
        next_s.tx_bits = s.tx_bits + 4'h1;
        unique case (s.tx_st)
          ufc_pkg::TXS_PREAMBLE: begin
            if (s.tx_bits == frame_bits(s.wl) - 4'h1) begin
              next_s.tx_st = ufc_pkg::TXS_READY;
            end
          end
          ufc_pkg::TXS_START: begin
            next_s.tx_st = ufc_pkg::TXS_DATA;
            next_s.tx_bits = 4'h0;
            next_s.txd = s.tx_shift[0];
          end
          ufc_pkg::TXS_DATA: begin
            next_s.tx_shift = {1'b0, s.tx_shift[8:1]};
            next_s.txd = s.tx_shift[1];
            if (s.tx_bits == data_bits(s.wl) - 4'h1) begin
              next_s.tx_st = ufc_pkg::TXS_STOP;
              next_s.txd = 1'b1;
            end
          end
          ufc_pkg::TXS_STOP: begin
            next_s.tx_st = ufc_pkg::TXS_READY;
            if (s.tde) begin
              next_s.tx_complete_flag = 1'b1;
            end
          end
          ufc_pkg::TXS_BRK_LOW: begin
            if (s.tx_bits == frame_bits(s.wl) - 4'h1) begin
              next_s.tx_st = ufc_pkg::TXS_BRK_STOP;
              next_s.txd = 1'b1;
              next_s.send_break_ctl = 1'b0;
            end
          end
          default: begin
            next_s.tx_st = ufc_pkg::TXS_READY;
          end
        endcase
      end
    end

    // Receiver
    if (!s.receive_enable_ctl) begin
      next_s.rx_st = ufc_pkg::RXS_IDLE;
      next_s.rx_hist = 3'h0;
    end else if (tick) begin
      next_s.rx_tick = p;
      unique case (s.rx_st)
        ufc_pkg::RXS_IDLE: begin
          next_s.rx_hist = {s.rx_hist[1:0], s.rx_s2};
          if (s.rx_hist == 3'h7 && zero_now) begin
            next_s.rx_st = ufc_pkg::RXS_START;
            next_s.rx_tick = 6'h01;
            next_s.za = 2'h0;
            next_s.zb = 2'h0;
            next_s.rx_noise = 1'b0;
          end
        end
        ufc_pkg::RXS_START: begin
          if ((p == ufc_pkg::PT_A0 || p == ufc_pkg::PT_A1 || p == ufc_pkg::PT_A2) && zero_now) begin
            next_s.za = s.za + 2'h1;
          end
          if (p >= ufc_pkg::PT_MID && p <= ufc_pkg::PT_DECIDE && zero_now) begin
            next_s.zb = s.zb + 2'h1;
          end
          if (p == ufc_pkg::PT_DECIDE) begin
            if (next_s.za >= 2'h2 && next_s.zb >= 2'h2) begin
              next_s.rx_noise = !(next_s.za == 2'h3 && next_s.zb == 2'h3);
            end else begin
              next_s.rx_st = ufc_pkg::RXS_IDLE;
              next_s.rx_hist = 3'h0;
            end
          end
          if (p == ufc_pkg::TICKS_BIT) begin
            next_s.rx_st = ufc_pkg::RXS_DATA;
            next_s.rx_tick = 6'h00;
            next_s.rx_bits = 4'h0;
            next_s.zb = 2'h0;
          end
        end
        ufc_pkg::RXS_DATA: begin
          if (p >= ufc_pkg::PT_MID && p <= ufc_pkg::PT_DECIDE && zero_now) begin
            next_s.zb = s.zb + 2'h1;
          end
          if (p == ufc_pkg::TICKS_BIT) begin
            next_s.rx_shift = {(s.zb < 2'h2), s.rx_shift[8:1]};
            next_s.rx_noise = s.rx_noise || (s.zb == 2'h1) || (s.zb == 2'h2);
            next_s.rx_tick = 6'h00;
            next_s.zb = 2'h0;
            next_s.rx_bits = s.rx_bits + 4'h1;
            if (s.rx_bits == data_bits(s.wl) - 4'h1) begin
              next_s.rx_st = ufc_pkg::RXS_STOP;
            end
          end
        end
        default: begin
          if (s.stop != ufc_pkg::STOP_HALF && p >= sp && p <= sp + 6'h02 && zero_now) begin
            next_s.zb = s.zb + 2'h1;
          end
          if (p == ((s.stop == ufc_pkg::STOP_TWO) ? ufc_pkg::TICKS_BIT : stop_ticks(s.stop))) begin
            next_s.rx_st = ufc_pkg::RXS_IDLE;
            next_s.rx_hist = {3{s.rx_s2}};
            next_s.rx_data = s.wl ? s.rx_shift : {1'b0, s.rx_shift[8:1]};
            next_s.rx_done = 1'b1;
            next_s.noise_error_flag = s.rx_noise;
            next_s.fef = (s.stop != ufc_pkg::STOP_HALF) && (s.zb >= 2'h2);
          end
        end
      endcase
    end

    // Register reads
    if (rd_i) begin
      unique case (addr_i)
        ufc_pkg::ADDR_DATA: next_s.rdata = {23'h0, s.rx_data};
        ufc_pkg::ADDR_STATUS: next_s.rdata = {27'h0, s.fef, s.noise_error_flag, s.rx_done, s.tx_complete_flag, s.tde};
        ufc_pkg::ADDR_CTRL1: next_s.rdata = {25'h0, s.rxdie, s.txcie, s.tdeie, s.send_break_ctl, s.receive_enable_ctl, s.transmit_enable_ctl, s.wl};
        ufc_pkg::ADDR_CTRL2: next_s.rdata = {30'h0, s.stop};
        ufc_pkg::ADDR_BAUD: next_s.rdata = {{(32-DIV_W){1'b0}}, s.baud};
        default: next_s.rdata = 32'h0000_0000;
      endcase
    end
    if (rd_sts) begin
      next_s.sts_seen = 1'b1;
    end
    if (rd_data && !rx_end) begin
      next_s.rx_done = 1'b0;
      if (s.sts_seen) begin
        next_s.noise_error_flag = 1'b0;
        next_s.fef = 1'b0;
      end
    end
    if (rd_data) begin
      next_s.sts_seen = 1'b0;
    end

    // Register writes
    if (wr_data) begin
      next_s.sts_seen = 1'b0;
      if (s.sts_seen && !tx_end) begin
        next_s.tx_complete_flag = 1'b0;
      end
      if (direct_ok) begin
        next_s.tx_st = ufc_pkg::TXS_START;
        next_s.tx_shift = wdata_i[8:0];
        next_s.tde = 1'b1;
        next_s.txd = 1'b0;
      end else begin
        next_s.hold = wdata_i[8:0];
        next_s.hold_full = 1'b1;
        next_s.tde = 1'b0;
      end
    end
    if (wr_sts) begin
      if (!wdata_i[ufc_pkg::ST_TXC] && !tx_end) begin
        next_s.tx_complete_flag = 1'b0;
      end
      if (!wdata_i[ufc_pkg::ST_RXD] && !rx_end) begin
        next_s.rx_done = 1'b0;
      end
    end
    if (wr_ctl1) begin
      next_s.wl = wdata_i[ufc_pkg::C1_WL];
      next_s.transmit_enable_ctl = wdata_i[ufc_pkg::C1_TRANSMIT_ENABLE_CTL];
      next_s.receive_enable_ctl = wdata_i[ufc_pkg::C1_RECEIVE_ENABLE_CTL];
      next_s.send_break_ctl = wdata_i[ufc_pkg::C1_SEND_BREAK_CTL];
      next_s.tdeie = wdata_i[ufc_pkg::C1_TDEIE];
      next_s.txcie = wdata_i[ufc_pkg::C1_TXCIE];
      next_s.rxdie = wdata_i[ufc_pkg::C1_RXDIE];
    end
    if (wr_i && addr_i == ufc_pkg::ADDR_CTRL2) begin
      next_s.stop = wdata_i[ufc_pkg::C2_STOP_LSB +: 2];
    end
    if (wr_i && addr_i == ufc_pkg::ADDR_BAUD) begin
      next_s.baud = wdata_i[DIV_W-1:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s <= '0;
      s.baud <= DIV_W'(ufc_pkg::BAUD_RST);
      s.stop <= ufc_pkg::STOP_RST;
      s.tde <= 1'b1;
      s.txd <= 1'b1;
      s.rx_s1 <= 1'b1;
      s.rx_s2 <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign rdata_o = s.rdata;
  assign tx_o = s.txd;
  assign irq_o = (s.tde && s.tdeie) || (s.tx_complete_flag && s.txcie) || (s.rx_done && s.rxdie);

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic tx_in_stop;
  logic rx_in_stop;
  logic rx_in_start;
  assign tx_in_stop = s.tx_st == ufc_pkg::TXS_STOP;
  assign rx_in_stop = s.rx_st == ufc_pkg::RXS_STOP;
  assign rx_in_start = s.rx_st == ufc_pkg::RXS_START;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  start_low_a: assert property ($rose(s.tx_st == ufc_pkg::TXS_START) |-> !tx_o)
    else $error("start bit not low");
  write_busy_a: assert property (wr_data && !direct_ok |=> !s.tde && s.hold_full)
    else $error("busy write did not hold data");
  write_direct_a: assert property (wr_data && direct_ok |=> s.tde && s.tx_st == ufc_pkg::TXS_START)
    else $error("idle write not loaded");
  enable_idle_a: assert property (s.transmit_enable_ctl && s.tx_st == ufc_pkg::TXS_OFF |=> s.tx_st == ufc_pkg::TXS_PREAMBLE)
    else $error("no idle frame after enable");
  brk_clear_a: assert property ($rose(s.tx_st == ufc_pkg::TXS_BRK_STOP) && !$past(wr_ctl1) |-> !s.send_break_ctl && tx_o)
    else $error("break control not cleared");
  brk_skip_a: assert property (s.tx_st == ufc_pkg::TXS_READY && !s.send_break_ctl && !wr_data
    |=> s.tx_st != ufc_pkg::TXS_BRK_LOW)
    else $error("break sent without request");
  txc_set_a: assert property ($rose(s.tx_complete_flag) |-> $past(tx_in_stop) && $past(s.tde))
    else $error("complete flag without frame end");
  abort_quiet_a: assert property (rx_in_start ##1 s.rx_st == ufc_pkg::RXS_IDLE |-> !$rose(s.noise_error_flag) && !$rose(s.rx_done))
    else $error("abandoned start raised a flag");
  rx_done_a: assert property ($rose(s.rx_done) |-> $past(rx_in_stop) && s.rx_st == ufc_pkg::RXS_IDLE)
    else $error("receive done outside frame end");
  half_nofe_a: assert property (s.stop == ufc_pkg::STOP_HALF && rx_in_stop |=> !$rose(s.fef))
    else $error("framing error with half stop");

  brk_sent_c: cover property ($rose(s.tx_st == ufc_pkg::TXS_BRK_STOP));
  noisy_start_c: cover property ($rose(s.noise_error_flag));
  rx_frame_c: cover property ($rose(s.rx_done));
  tx_done_c: cover property ($rose(s.tx_complete_flag));

endmodule : ufc_core

`default_nettype wire

// ==== testbench/ufc_remote.sv ====
`timescale 1ns/1ps
`default_nettype none

module ufc_remote (
  // Clock
  input wire logic clk_i,
  // Serial lines and data bit count
  input wire logic tx_i,
  input wire logic [3:0] nbits_i,
  output logic rx_o
);
  logic [9:0] got_q[$];
  time start_q[$];

  initial rx_o = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Frame decoder: data in bits 8:0, stop level in bit 9
  always begin : decode
    logic [9:0] w;
    w = '0;
    @(negedge tx_i);
    start_q.push_back($time);
    repeat (8) @(posedge clk_i);
    for (int i = 0; i < nbits_i; i++) begin
      repeat (16) @(posedge clk_i);
      w[i] = tx_i;
    end
    // Stop is sampled early so a half stop never hides the next start
    repeat (12) @(posedge clk_i);
    w[9] = tx_i;
    got_q.push_back(w);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame sender, one clock per sample tick; line idles high
  task automatic send(input logic [8:0] d, input int nb, input logic [15:0] sp, input logic stp);
    for (int k = 0; k < 16; k++) begin
      @(posedge clk_i);
      rx_o <= sp[k];
    end
    for (int i = 0; i < nb; i++) begin
      @(posedge clk_i);
      rx_o <= d[i];
      repeat (15) @(posedge clk_i);
    end
    @(posedge clk_i);
    rx_o <= stp;
    repeat (24) @(posedge clk_i);
    rx_o <= 1'b1;
    repeat (16) @(posedge clk_i);
  endtask : send

  // Short low pulse that must not pass as a start bit
  task automatic glitch(input int n);
    @(posedge clk_i);
    rx_o <= 1'b0;
    repeat (n) @(posedge clk_i);
    rx_o <= 1'b1;
  endtask : glitch
endmodule : ufc_remote

`default_nettype wire

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic clk_i;
  logic rst_b_i;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  logic tx;
  logic irq;
  logic [3:0] nbits;
  logic rx;
  int bad_count;
  int checks;
  int cyc;
  time t0;
  logic [31:0] v;
  int stop_t[4] = '{16, 8, 32, 24};

  ufc_core #(.DIV_W(16)) dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .rx_i(rx), .tx_o(tx), .irq_o(irq)
  );

  ufc_remote remote (.clk_i(clk_i), .tx_i(tx), .nbits_i(nbits), .rx_o(rx));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic exp_reg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1;
    check(rdata & m, e);
  endtask : exp_reg

  task automatic wait_tx(input logic lvl);
    int n;
    n = 0;
    while (tx !== lvl && n < 2000) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    if (n >= 2000) check(32'h0, 32'h1);
  endtask : wait_tx

  task automatic wait_q(input int n);
    int k;
    k = 0;
    while (remote.got_q.size() < n && k < 2000) begin
      @(posedge clk_i);
      k++;
    end
    repeat (40) @(posedge clk_i);
  endtask : wait_q

  task automatic summarize;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst_b_i = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    nbits = 4'h8;
    bad_count = 0;
    checks = 0;
    cyc = 0;
    repeat (5) @(posedge clk_i);
    rst_b_i <= 1'b1;
    exp_reg(ufc_pkg::ADDR_STATUS, 32'hffffffff, 32'h1);
    exp_reg(ufc_pkg::ADDR_CTRL1, 32'hffffffff, 32'h0);
    exp_reg(ufc_pkg::ADDR_CTRL2, 32'hffffffff, 32'h0);
    exp_reg(ufc_pkg::ADDR_BAUD, 32'hffffffff, 32'h1b);
    exp_reg(8'h14, 32'hffffffff, 32'h0);
    // Transmit: idle frame first, then two loads through holding
    wr_reg(ufc_pkg::ADDR_BAUD, 32'h1);
    wr_reg(ufc_pkg::ADDR_CTRL1, 32'h6);
    t0 = $time;
    wr_reg(ufc_pkg::ADDR_DATA, 32'ha5);
    exp_reg(ufc_pkg::ADDR_STATUS, 32'h1, 32'h0);
    wait_tx(1'b0);
    check(32'(($time - t0) >= 3200), 32'h1);
    wr_reg(ufc_pkg::ADDR_DATA, 32'h5a);
    exp_reg(ufc_pkg::ADDR_STATUS, 32'h3, 32'h0);
    wait_q(2);
    check(32'(remote.got_q[0]), 32'h2a5);
    check(32'(remote.got_q[1]), 32'h25a);
    exp_reg(ufc_pkg::ADDR_STATUS, 32'h3, 32'h3);
    wr_reg(ufc_pkg::ADDR_STATUS, 32'h0);
    exp_reg(ufc_pkg::ADDR_STATUS, 32'h3, 32'h1);
    // Nine-bit word, loaded straight into the idle shifter
    remote.got_q.delete();
    nbits <= 4'h9;
    wr_reg(ufc_pkg::ADDR_CTRL1, 32'h7);
    wr_reg(ufc_pkg::ADDR_DATA, 32'h1a5);
    exp_reg(ufc_pkg::ADDR_STATUS, 32'h1, 32'h1);
    wait_q(1);
    check(32'(remote.got_q[0]), 32'h3a5);
    // Stop length for every code, from start to start of two frames
    nbits <= 4'h8;
    wr_reg(ufc_pkg::ADDR_CTRL1, 32'h6);
    for (int c = 0; c < 4; c++) begin
      remote.got_q.delete();
      remote.start_q.delete();
      wr_reg(ufc_pkg::ADDR_CTRL2, 32'(c));
      wr_reg(ufc_pkg::ADDR_DATA, 32'h81);
      wr_reg(ufc_pkg::ADDR_DATA, 32'h7e);
      wait_q(2);
      // One clock in the ready state before the held word is loaded
      check(32'((remote.start_q[1] - remote.start_q[0]) / 20), 32'(145 + stop_t[c]));
    end
    // Break frame and its self-clearing control
    wr_reg(ufc_pkg::ADDR_CTRL2, 32'h0);
    wr_reg(ufc_pkg::ADDR_CTRL1, 32'he);
    wait_tx(1'b0);
    t0 = $time;
    wait_tx(1'b1);
    check(32'(($time - t0) / 20), 32'd160);
    exp_reg(ufc_pkg::ADDR_CTRL1, 32'hffffffff, 32'h6);
    repeat (40) @(posedge clk_i);
    // Break requested and withdrawn while a frame is out: no break follows
    remote.got_q.delete();
    wr_reg(ufc_pkg::ADDR_DATA, 32'hff);
    wr_reg(ufc_pkg::ADDR_CTRL1, 32'he);
    wr_reg(ufc_pkg::ADDR_CTRL1, 32'h6);
    wait_q(1);
    repeat (200) @(posedge clk_i);
    check(32'(remote.got_q.size()), 32'h1);
    // Receive: low stop for every stop code
    for (int c = 0; c < 4; c++) begin
      wr_reg(ufc_pkg::ADDR_CTRL2, 32'(c));
      remote.send(9'h03c, 8, 16'h0000, 1'b0);
      exp_reg(ufc_pkg::ADDR_STATUS, 32'h1c, (c == 1) ? 32'h04 : 32'h14);
      exp_reg(ufc_pkg::ADDR_DATA, 32'h1ff, 32'h3c);
    end
    // Noisy start, clean start, rejected glitch
    wr_reg(ufc_pkg::ADDR_CTRL2, 32'h0);
    wr_reg(ufc_pkg::ADDR_CTRL1, 32'h46);
    remote.send(9'h096, 8, 16'h0004, 1'b1);
    check(32'(irq), 32'h1);
    exp_reg(ufc_pkg::ADDR_STATUS, 32'h1c, 32'h0c);
    exp_reg(ufc_pkg::ADDR_DATA, 32'h1ff, 32'h96);
    remote.send(9'h069, 8, 16'h0000, 1'b1);
    exp_reg(ufc_pkg::ADDR_STATUS, 32'h1c, 32'h04);
    exp_reg(ufc_pkg::ADDR_DATA, 32'h1ff, 32'h69);
    remote.glitch(4);
    repeat (300) @(posedge clk_i);
    exp_reg(ufc_pkg::ADDR_STATUS, 32'h1c, 32'h0);
    check(32'(irq), 32'h0);
    summarize();
  end
endmodule : tb_top

`default_nettype wire
